// >>> hdl/fbp_pkg.sv
// Constants for the flash block protection unit: register offsets, fields, reset values.
// Assumes a plain register port with byte offsets and 32-bit data.
package fbp_pkg;
   localparam logic [11:0] OFF_ADDR      = 12'h000; // Flash target address
   localparam logic [11:0] OFF_CTRL      = 12'h008; // Flash command control
   localparam logic [11:0] OFF_RAW       = 12'h00C; // Raw event status
   localparam logic [11:0] OFF_MASK      = 12'h010; // Event mask
   localparam logic [11:0] OFF_CLR       = 12'h014; // Masked status and clear
   localparam logic [11:0] OFF_RDPOL     = 12'h130; // Read enable policy
   localparam logic [11:0] OFF_PGPOL     = 12'h134; // Program enable policy
   localparam int          CTRL_WRITE    = 0;
   localparam int          CTRL_ERASE    = 1;
   localparam int          CTRL_MERASE   = 2;
   localparam int          CTRL_COMMIT   = 3;
   localparam int          EV_ACCESS     = 0;       // Access violation event bit
   localparam int          EV_PROG       = 1;       // Programming complete event bit
   localparam int          BLK_LSB       = 11;      // 2-KB block index starts here
   localparam int          DBG_LSB       = 30;      // Debug gate field position
   localparam logic [1:0]  DBG_OPEN      = 2'h2;    // Field value allowing debug port
   localparam logic [31:0] RDPOL_RESET   = 32'h800000FF;
   localparam logic [31:0] PGPOL_RESET   = 32'h000000FF;
   localparam logic [31:0] DBG_COMMIT_AD = 32'h00000900;
   localparam int          COMMIT_CYC    = 4;       // Commit write sequence length
endpackage

// >>> hdl/fbp_unit.sv
// Flash block protection unit: policy registers, commit, access checks, events, debug gate.
// Assumes the flash engine pulses op_done and that a power-on reset drives rst_n.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
// Function
// [RULE1] Per 2-KB block one program-enable and one read-enable bit in 32-bit registers.
// [RULE2] Program-enable set allows program and erase; clear refuses them.
// [RULE3] Read-enable clear permits instruction fetch only, refuses data reads.
// [RULE4] Two bits combine into execute-only, write-only, read-only or open.
// [RULE5] Forbidden data read is blocked and answered with a bus fault.
// [RULE6] Forbidden program or erase suppressed; interrupt only when violation mask set.
// [RULE7] All implemented policy bits start at one.
// [RULE8] Software may only clear policy bits; setting has no effect.
// [RULE9] Cleared bits are temporary until commit, then permanent.
// [RULE10] Power-on reset restores uncommitted cleared bits to one.
// [RULE11] Programming-complete event raised when program or erase finishes.
// [RULE12] Access-violation event raised on program or erase of protected block.
// [RULE13] Raw flags always visible; only masked events drive interrupt and masked status.
// [RULE14] Writing one to clear register clears raw and masked; zero leaves it.
// [RULE15] Debug port open when debug field is 0x2, denied when cleared.
// [RULE16] Committed cleared debug field can never return to factory value.
// [RULE17] Committed debug disable applies from next power-up only; the code latches it at every reset release.
// [RULE18] Test access port stays usable; only the debug port path is cut.
// [RULE19] Software should clear execute-only read bits in the debug commit.
// [RULE20] Software sets address bit 0 to pick program or read register commit.
// [RULE21] Software loads address 0x900 before committing the debug field.
// [RULE22] Commit bit reads set while committing and clears when done.
// [RULE23] Block bit chosen from flash address bits above bit 10.
module fbp_unit (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic [11:0] reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        rd_req,
   input  wire logic        rd_is_fetch,
   input  wire logic [31:0] rd_addr,
   output logic             rd_grant,
   output logic             rd_fault,
   output logic             pe_start,
   output logic             pe_write,
   output logic             pe_erase,
   output logic             pe_mass,
   output logic      [31:0] pe_addr,
   input  wire logic        op_done,
   output logic             flash_irq,
   output logic             dap_enable,
   output logic             tap_enable
);
   typedef struct packed {
      logic [31:0] addr;
      // [RULE1] one bit per 2-KB block
      logic [31:0] rdpol;    // Live read policy
      logic [31:0] pgpol;    // Live program policy
      logic [31:0] rdperm;   // Committed read policy
      logic [31:0] pgperm;   // Committed program policy
      logic [1:0]  ev_raw;
      logic [1:0]  ev_mask;
      logic [2:0]  cmd;      // Busy write, erase, mass erase
      logic        commit;
      logic [2:0]  ccnt;
      logic [1:0]  csel;     // 0 read, 1 program, 2 debug
      logic        dbg_sess; // Debug latched for this session
      logic        booted;   // Survives later resets; unknown only before power-on
      logic        latched;  // Debug gate captured since the last reset
      logic [31:0] rdata;
      logic        grant;
      logic        fault;
      logic        start;
      logic        irq;
      logic        tap;
   } fbp_state_t;

   fbp_state_t s_r;
   fbp_state_t s_nxt;
   logic [2:0] wr_cmd;

   localparam int BLK_LSB_W = 5;

   // Policy bit of the 2-KB block holding an address
   function automatic logic blk_bit(input logic [31:0] pol, input logic [31:0] a);
      blk_bit = pol[a[BLK_LSB_W+fbp_pkg::BLK_LSB-1:fbp_pkg::BLK_LSB]];
   endfunction

   // Program or erase allowed; mass erase needs every implemented block open
   function automatic logic pe_ok(input logic [2:0] c, input logic [31:0] pol, input logic [31:0] a);
      pe_ok = c[2] ? (&pol[7:0]) : blk_bit(pol, a);
   endfunction

   assign wr_cmd = {reg_wdata[fbp_pkg::CTRL_MERASE], reg_wdata[fbp_pkg::CTRL_ERASE], reg_wdata[fbp_pkg::CTRL_WRITE]};

   // Next state of the whole unit
   always_comb begin
      s_nxt       = s_r;
      s_nxt.grant = 1'b0;
      s_nxt.fault = 1'b0;
      s_nxt.start = 1'b0;
      s_nxt.rdata = 32'h00000000;
      // Capture of the committed debug state, once after each reset release
      // [RULE17] session debug latch
      if (!s_r.latched) begin
         s_nxt.latched  = 1'b1;
         s_nxt.dbg_sess = (s_r.rdperm[fbp_pkg::DBG_LSB+1:fbp_pkg::DBG_LSB] == fbp_pkg::DBG_OPEN);
      end
      // Data read check; fetch always passes
      // [RULE3] [RULE4] [RULE5] [RULE23] read policy check
      if (rd_req) begin
         if (rd_is_fetch || blk_bit(s_r.rdpol, rd_addr)) begin
            s_nxt.grant = 1'b1;
         end else begin
            s_nxt.fault = 1'b1;
         end
      end
      // Program/erase finished
      // [RULE11] completion event
      if (op_done && (s_r.cmd != 3'h0)) begin
         s_nxt.cmd = 3'h0;
      end
      // Commit sequence countdown
      // [RULE9] [RULE22] commit permanent
      if (s_r.commit) begin
         if (s_r.ccnt == 3'h0) begin
            s_nxt.commit = 1'b0;
            case (s_r.csel)
               2'h1: s_nxt.pgperm = s_r.pgperm & s_r.pgpol;
               2'h2: s_nxt.rdperm = s_r.rdperm & s_r.rdpol;
               default: s_nxt.rdperm = s_r.rdperm & {2'h3, s_r.rdpol[29:0]};
            endcase
         end else begin
            s_nxt.ccnt = s_r.ccnt - 3'h1;
         end
      end
      // Register writes
      if (reg_wr) begin
         case (reg_addr)
            fbp_pkg::OFF_ADDR: s_nxt.addr = reg_wdata;
            fbp_pkg::OFF_MASK: s_nxt.ev_mask = reg_wdata[1:0];
            // [RULE8] clear-only policy write
            fbp_pkg::OFF_RDPOL: s_nxt.rdpol = s_r.rdpol & reg_wdata;
            fbp_pkg::OFF_PGPOL: s_nxt.pgpol = s_r.pgpol & reg_wdata;
            fbp_pkg::OFF_CTRL: begin
               if (reg_wdata[fbp_pkg::CTRL_COMMIT] && !s_r.commit && s_r.cmd == 3'h0) begin
                  s_nxt.commit = 1'b1;
                  s_nxt.ccnt   = 3'(fbp_pkg::COMMIT_CYC - 1);
                  // [RULE16] debug commit selection
                  if (s_r.addr == fbp_pkg::DBG_COMMIT_AD) s_nxt.csel = 2'h2;
                  else s_nxt.csel = {1'b0, s_r.addr[0]};
               end else if (wr_cmd != 3'h0 && s_r.cmd == 3'h0 && !s_r.commit) begin
                  // [RULE2] [RULE6] [RULE12] program guard
                  if (pe_ok(wr_cmd, s_r.pgpol, s_r.addr)) begin
                     s_nxt.cmd   = wr_cmd;
                     s_nxt.start = 1'b1;
                  end else begin
                     s_nxt.ev_raw[fbp_pkg::EV_ACCESS] = 1'b1;
                  end
               end
            end
            default: ;
         endcase
      end
      // Event clear; a same-cycle set wins
      // [RULE14] write-one clear
      if (reg_wr && reg_addr == fbp_pkg::OFF_CLR) begin
         s_nxt.ev_raw = s_nxt.ev_raw & ~reg_wdata[1:0];
      end
      if (op_done && (s_r.cmd != 3'h0)) s_nxt.ev_raw[fbp_pkg::EV_PROG] = 1'b1;
      if (reg_wr && reg_addr == fbp_pkg::OFF_CTRL && wr_cmd != 3'h0 && s_r.cmd == 3'h0 && !s_r.commit &&
          !reg_wdata[fbp_pkg::CTRL_COMMIT] &&
          !pe_ok(wr_cmd, s_r.pgpol, s_r.addr))
         s_nxt.ev_raw[fbp_pkg::EV_ACCESS] = 1'b1;
      // [RULE13] masked interrupt
      s_nxt.irq = |(s_nxt.ev_raw & s_nxt.ev_mask);
      // Register reads, answered next cycle
      if (reg_rd) begin
         case (reg_addr)
            fbp_pkg::OFF_ADDR:  s_nxt.rdata = s_r.addr;
            fbp_pkg::OFF_CTRL:  s_nxt.rdata = {28'h0000000, s_r.commit, s_r.cmd};
            fbp_pkg::OFF_RAW:   s_nxt.rdata = {30'h00000000, s_r.ev_raw};
            fbp_pkg::OFF_MASK:  s_nxt.rdata = {30'h00000000, s_r.ev_mask};
            fbp_pkg::OFF_CLR:   s_nxt.rdata = {30'h00000000, s_r.ev_raw & s_r.ev_mask};
            fbp_pkg::OFF_RDPOL: s_nxt.rdata = s_r.rdpol;
            fbp_pkg::OFF_PGPOL: s_nxt.rdata = s_r.pgpol;
            default:            s_nxt.rdata = 32'h00000000;
         endcase
      end
   end

   // State register; reset reloads live policy from committed copies
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         // [RULE7] [RULE10] reset policy; only the first reset is power-on
         s_r        <= '0;
         s_r.booted <= 1'b1;
         s_r.tap    <= 1'b1;
         // Flag kept over long resets, else commits would be lost
         if (s_r.booted == 1'b1) begin
            s_r.rdpol  <= s_r.rdperm;
            s_r.pgpol  <= s_r.pgperm;
            s_r.rdperm <= s_r.rdperm;
            s_r.pgperm <= s_r.pgperm;
         end else begin
            s_r.rdpol  <= fbp_pkg::RDPOL_RESET;
            s_r.pgpol  <= fbp_pkg::PGPOL_RESET;
            s_r.rdperm <= fbp_pkg::RDPOL_RESET;
            s_r.pgperm <= fbp_pkg::PGPOL_RESET;
         end
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from state
   assign reg_rdata  = s_r.rdata;
   assign rd_grant   = s_r.grant;
   assign rd_fault   = s_r.fault;
   assign pe_start   = s_r.start;
   assign pe_write   = s_r.cmd[0];
   assign pe_erase   = s_r.cmd[1];
   assign pe_mass    = s_r.cmd[2];
   assign pe_addr    = s_r.addr;
   assign flash_irq  = s_r.irq;
   // [RULE15] debug port gate
   assign dap_enable = s_r.dbg_sess;
   // [RULE18] tap always usable
   assign tap_enable = s_r.tap;

   // Checks
   chk_read_fault: assert property (@(posedge clock) disable iff (!rst_n) // [RULE5]
      rd_req && !rd_is_fetch && !blk_bit(s_r.rdpol, rd_addr) |=> rd_fault && !rd_grant)
      else $error("forbidden read not faulted");
   chk_fetch_ok: assert property (@(posedge clock) disable iff (!rst_n) // [RULE3]
      rd_req && rd_is_fetch |=> rd_grant) else $error("fetch refused");
   chk_clear_only: assert property (@(posedge clock) disable iff (!rst_n) // [RULE8]
      ((s_r.rdpol & ~$past(s_r.rdpol)) == 32'h0) && ((s_r.pgpol & ~$past(s_r.pgpol)) == 32'h0))
      else $error("policy bit set by software");
   chk_irq_mask: assert property (@(posedge clock) disable iff (!rst_n) // [RULE13]
      flash_irq == |(s_r.ev_raw & s_r.ev_mask)) else $error("irq mismatch");
   chk_prog_event: assert property (@(posedge clock) disable iff (!rst_n) // [RULE11]
      op_done && s_r.cmd != 3'h0 |=> s_r.ev_raw[fbp_pkg::EV_PROG] && s_r.cmd == 3'h0)
      else $error("no completion event");
   chk_guard_start: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
      pe_start && !pe_mass |-> blk_bit(s_r.pgpol, s_r.addr)) else $error("protected block started");
   chk_commit_len: assert property (@(posedge clock) disable iff (!rst_n) // [RULE22]
      $rose(s_r.commit) |-> s_r.commit [*4] ##1 !s_r.commit) else $error("commit length wrong");
   chk_dap_stable: assert property (@(posedge clock) disable iff (!rst_n) // [RULE17]
      s_r.latched && $past(s_r.latched) |-> $stable(dap_enable)) else $error("debug gate changed in session");
   chk_perm_hold: assert property (@(posedge clock) disable iff (!rst_n) // [RULE9]
      ((s_r.pgperm & ~$past(s_r.pgperm)) == 32'h0)) else $error("committed bit restored");
   cov_fault: cover property (@(posedge clock) rd_fault);
   cov_violation: cover property (@(posedge clock) $rose(s_r.ev_raw[fbp_pkg::EV_ACCESS]));
   cov_commit: cover property (@(posedge clock) $fell(s_r.commit));
   cov_dbg_commit: cover property (@(posedge clock) $fell(s_r.commit) && s_r.csel == 2'h2);
   cov_mass_start: cover property (@(posedge clock) pe_start && pe_mass);

   // Further checks on the bus answers, events, commit and gates
   // [RULE5] one answer per request
   chk_answer_excl: assert property (@(posedge clock) disable iff (!rst_n) // [RULE5]
      !(rd_grant && rd_fault))
      else $error("grant and fault together");

   // [RULE3] permitted data read
   chk_open_read: assert property (@(posedge clock) disable iff (!rst_n) // [RULE3]
      rd_req && !rd_is_fetch && blk_bit(s_r.rdpol, rd_addr)
      |=> rd_grant && !rd_fault)
      else $error("permitted read refused");

   // [RULE5] no answer without request
   chk_quiet_bus: assert property (@(posedge clock) disable iff (!rst_n) // [RULE5]
      !rd_req
      |=> !rd_grant && !rd_fault)
      else $error("answer without request");

   // [RULE12] violation event raised
   chk_prot_event: assert property (@(posedge clock) disable iff (!rst_n) // [RULE12]
      reg_wr && reg_addr == fbp_pkg::OFF_CTRL && !reg_wdata[fbp_pkg::CTRL_COMMIT] && wr_cmd != 3'h0 &&
      s_r.cmd == 3'h0 && !s_r.commit && !pe_ok(wr_cmd, s_r.pgpol, s_r.addr)
      |=> s_r.ev_raw[fbp_pkg::EV_ACCESS])
      else $error("violation not flagged");

   // [RULE6] protected change suppressed
   chk_prot_nostart: assert property (@(posedge clock) disable iff (!rst_n) // [RULE6]
      reg_wr && reg_addr == fbp_pkg::OFF_CTRL && !pe_ok(wr_cmd, s_r.pgpol, s_r.addr)
      |=> !pe_start)
      else $error("protected change started");

   // [RULE2] mass erase guard
   chk_mass_guard: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
      pe_start && pe_mass
      |-> (&s_r.pgpol[7:0]))
      else $error("mass erase on protected flash");

   // [RULE2] start means busy
   chk_start_busy: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
      pe_start
      |-> s_r.cmd != 3'h0)
      else $error("start without command");

   // [RULE2] no start while busy
   chk_busy_refuse: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
      s_r.cmd != 3'h0 && $past(s_r.cmd) != 3'h0
      |-> !pe_start)
      else $error("start while busy");

   // [RULE14] write one clears
   chk_clear_raw: assert property (@(posedge clock) disable iff (!rst_n) // [RULE14]
      reg_wr && reg_addr == fbp_pkg::OFF_CLR && reg_wdata[fbp_pkg::EV_PROG] && !op_done
      |=> !s_r.ev_raw[fbp_pkg::EV_PROG])
      else $error("event not cleared");

   // [RULE14] write zero keeps
   chk_clear_zero: assert property (@(posedge clock) disable iff (!rst_n) // [RULE14]
      reg_wr && reg_addr == fbp_pkg::OFF_CLR && !reg_wdata[fbp_pkg::EV_ACCESS] && s_r.ev_raw[fbp_pkg::EV_ACCESS]
      |=> s_r.ev_raw[fbp_pkg::EV_ACCESS])
      else $error("event lost on zero write");

   // [RULE13] raw flags readable
   chk_raw_visible: assert property (@(posedge clock) disable iff (!rst_n) // [RULE13]
      reg_rd && reg_addr == fbp_pkg::OFF_RAW
      |=> reg_rdata[1:0] == $past(s_r.ev_raw))
      else $error("raw status read wrong");

   // [RULE13] masked status read
   chk_masked_read: assert property (@(posedge clock) disable iff (!rst_n) // [RULE13]
      reg_rd && reg_addr == fbp_pkg::OFF_CLR
      |=> reg_rdata[1:0] == ($past(s_r.ev_raw) & $past(s_r.ev_mask)))
      else $error("masked status read wrong");

   // [RULE22] commit bit readable
   chk_commit_bit: assert property (@(posedge clock) disable iff (!rst_n) // [RULE22]
      reg_rd && reg_addr == fbp_pkg::OFF_CTRL
      |=> reg_rdata[fbp_pkg::CTRL_COMMIT] == $past(s_r.commit))
      else $error("commit bit read wrong");

   // [RULE22] no start while committing
   chk_commit_quiet: assert property (@(posedge clock) disable iff (!rst_n) // [RULE22]
      s_r.commit
      |-> !pe_start)
      else $error("start during commit");

   // [RULE16] committed read bits stay clear
   chk_rd_perm_hold: assert property (@(posedge clock) disable iff (!rst_n) // [RULE16]
      1'b1
      |-> (s_r.rdperm & ~$past(s_r.rdperm)) == 32'h0)
      else $error("committed read bit restored");

   // [RULE9] live never above committed
   chk_live_le_perm: assert property (@(posedge clock) disable iff (!rst_n) // [RULE9]
      1'b1
      |-> ((s_r.rdpol & ~s_r.rdperm) == 32'h0) && ((s_r.pgpol & ~s_r.pgperm) == 32'h0))
      else $error("live policy above committed");

   // [RULE10] reset reloads committed copies
   chk_reset_restore: assert property (@(posedge clock) // [RULE10]
      !rst_n
      |=> s_r.rdpol == s_r.rdperm && s_r.pgpol == s_r.pgperm)
      else $error("reset kept uncommitted clears");

   // [RULE18] test port usable
   chk_tap_open: assert property (@(posedge clock) disable iff (!rst_n) // [RULE18]
      1'b1
      |-> tap_enable)
      else $error("test port cut");

   // [RULE15] gate follows committed field
   chk_gate_value: assert property (@(posedge clock) disable iff (!rst_n) // [RULE15]
      $rose(s_r.latched)
      |-> dap_enable == (s_r.rdperm[fbp_pkg::DBG_LSB+1:fbp_pkg::DBG_LSB] == fbp_pkg::DBG_OPEN))
      else $error("debug gate value wrong");

   // [RULE1] program policy readable
   chk_pol_read: assert property (@(posedge clock) disable iff (!rst_n) // [RULE1]
      reg_rd && reg_addr == fbp_pkg::OFF_PGPOL
      |=> reg_rdata == $past(s_r.pgpol))
      else $error("policy read wrong");

   // [RULE6] interrupt needs a mask bit
   chk_irq_needs_mask: assert property (@(posedge clock) disable iff (!rst_n) // [RULE6]
      flash_irq
      |-> s_r.ev_mask != 2'h0)
      else $error("unmasked interrupt");

   // [RULE11] busy ends on done
   chk_done_idle: assert property (@(posedge clock) disable iff (!rst_n) // [RULE11]
      op_done && s_r.cmd != 3'h0
      |=> !pe_write && !pe_erase && !pe_mass)
      else $error("busy after done");
endmodule

// >>> verification/fbp_engine_model.sv
// Program/erase engine model facing the protection unit.
// Assumes pe_start is a one-cycle pulse; answers with one op_done pulse.
`timescale 1ns/100ps
module fbp_engine_model #(
   parameter int DLY = 5
) (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic pe_start,
   output logic      op_done
);
   int cnt;
   // Fixed busy time; a real engine is never instant
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cnt     <= 0;
         op_done <= 1'b0;
      end else begin
         op_done <= (cnt == 1);
         if (pe_start) cnt <= DLY;
         else if (cnt > 0) cnt <= cnt - 1;
      end
   end
endmodule

// >>> verification/tb.sv
// Self-checking bench for the flash block protection unit.
// Assumes the engine model stands in for the program/erase engine.
`timescale 1ns/100ps
module tb;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0, rd_addr = 32'h0, reg_rdata, pe_addr, d;
   logic        reg_wr = 1'b0, reg_rd = 1'b0, rd_req = 1'b0, rd_is_fetch = 1'b0;
   logic        rd_grant, rd_fault, pe_start, pe_write, pe_erase, pe_mass;
   logic        op_done, flash_irq, dap_enable, tap_enable;
   int          checks = 0, err_total = 0;
   fbp_unit u_dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .rd_req, .rd_is_fetch, .rd_addr, .rd_grant, .rd_fault, .pe_start, .pe_write,
      .pe_erase, .pe_mass, .pe_addr, .op_done, .flash_irq, .dap_enable, .tap_enable);
   fbp_engine_model u_eng (.clock, .rst_n, .pe_start, .op_done);
   // Free-running system clock
   always #20 clock = ~clock;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge clock);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [11:0] a);
      @(posedge clock);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic do_reset(input int n);
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (n) @(posedge clock);
      rst_n <= 1'b1;
      repeat (2) @(posedge clock);
   endtask
   // Command with bounded wait for the engine when it is expected to start
   task automatic cmd(input logic [31:0] a, input logic [31:0] c, input logic go);
      wr(fbp_pkg::OFF_ADDR, a);
      wr(fbp_pkg::OFF_CTRL, c);
      #1;
      chk(pe_start, go);
      if (go) begin
         chk({pe_mass, pe_erase, pe_write}, c[2:0]);
         chk(pe_addr, a);
         repeat (40) if (op_done !== 1'b1) begin
            @(posedge clock);
            #1;
         end
         chk(op_done, 1'b1);
         @(posedge clock);
         #1;
         chk({pe_mass, pe_erase, pe_write}, 3'h0);
      end
   endtask
   task automatic commit(input logic [31:0] a);
      wr(fbp_pkg::OFF_ADDR, a);
      wr(fbp_pkg::OFF_CTRL, 32'h00000008);
      rd(fbp_pkg::OFF_CTRL);
      chk(d[3], 1'b1);
      for (int i = 0; i < 10 && d[3]; i++) rd(fbp_pkg::OFF_CTRL);
      chk(d[3], 1'b0);
   endtask
   task automatic fetch(input logic [31:0] a, input logic f, input logic g);
      @(posedge clock);
      rd_req      <= 1'b1;
      rd_addr     <= a;
      rd_is_fetch <= f;
      @(posedge clock);
      rd_req <= 1'b0;
      #1;
      chk({rd_grant, rd_fault}, {g, !g});
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Watchdog far beyond the few hundred cycles the tests need
   initial begin
      #2000000;
      err_total++;
      complete_run;
   end
   initial begin
      do_reset(12);
      rd(fbp_pkg::OFF_RDPOL);
      chk(d, fbp_pkg::RDPOL_RESET);
      rd(fbp_pkg::OFF_PGPOL);
      chk(d, fbp_pkg::PGPOL_RESET);
      rd(12'h0FC);
      chk(d, 32'h0);
      chk({dap_enable, tap_enable}, 2'h3);
      $display("reset test done");
      // Write, erase and mass erase on open blocks, then event clearing
      for (int i = 0; i < 3; i++) begin
         cmd(32'h0, 32'h1 << i, 1'b1);
         rd(fbp_pkg::OFF_RAW);
         chk(d, 32'h2);
         wr(fbp_pkg::OFF_CLR, 32'h0);
         rd(fbp_pkg::OFF_RAW);
         chk(d, 32'h2);
         wr(fbp_pkg::OFF_CLR, 32'h2);
         rd(fbp_pkg::OFF_RAW);
         chk(d, 32'h0);
      end
      $display("program test done");
      wr(fbp_pkg::OFF_PGPOL, 32'h000000FD);
      wr(fbp_pkg::OFF_PGPOL, 32'h000000FF);
      rd(fbp_pkg::OFF_PGPOL);
      chk(d, 32'h000000FD);
      cmd(32'h00000800, 32'h1, 1'b0);
      cmd(32'h00000FFC, 32'h2, 1'b0);
      cmd(32'h0, 32'h4, 1'b0);
      rd(fbp_pkg::OFF_RAW);
      chk({flash_irq, d}, {1'b0, 32'h1});
      wr(fbp_pkg::OFF_MASK, 32'h1);
      rd(fbp_pkg::OFF_CLR);
      chk({flash_irq, d}, {1'b1, 32'h1});
      wr(fbp_pkg::OFF_CLR, 32'h1);
      rd(fbp_pkg::OFF_RAW);
      chk({flash_irq, d}, {1'b0, 32'h0});
      wr(fbp_pkg::OFF_MASK, 32'h0);
      $display("violation test done");
      wr(fbp_pkg::OFF_RDPOL, 32'h800000FB);
      fetch(32'h00001000, 1'b0, 1'b0);
      fetch(32'h000017FC, 1'b1, 1'b1);
      fetch(32'h00001800, 1'b0, 1'b1);
      fetch(32'h00000800, 1'b0, 1'b1);
      $display("read test done");
      commit(32'h00000001);
      do_reset(2);
      rd(fbp_pkg::OFF_PGPOL);
      chk(d, 32'h000000FD);
      rd(fbp_pkg::OFF_RDPOL);
      chk(d, fbp_pkg::RDPOL_RESET);
      $display("commit test done");
      // Debug gate cleared with a write-only block (read bit clear, program bit set) in the same commit
      wr(fbp_pkg::OFF_RDPOL, 32'h0000007F);
      commit(fbp_pkg::DBG_COMMIT_AD);
      chk(dap_enable, 1'b1);
      do_reset(2);
      chk({dap_enable, tap_enable}, 2'h1);
      wr(fbp_pkg::OFF_RDPOL, 32'hFFFFFFFF);
      rd(fbp_pkg::OFF_RDPOL);
      chk(d, 32'h0000007F);
      $display("debug test done");
      complete_run;
   end
endmodule
